// *** design/pgw_pkg.sv ***
// pgw_pkg: constants, register map and field layout of the power good prewarning block
// assumes a 50 MHz pclk and an apb master with 32-bit data
package pgw_pkg;
    localparam int CLK_HZ            = 50_000_000;
    localparam int MS_PER_S          = 1000;
    localparam int MS_CYCLES_DEF     = CLK_HZ / MS_PER_S;
    localparam int RAMP_STEPS        = 255;
    localparam int TMR_W             = 11;
    localparam int DIV_W             = 20;
    localparam int SYNC_W            = 8;
    localparam int IRQ_W             = 5;
    // times in ms and voltages in mV
    localparam int PG_TIME_STEP_MS   = 2;
    localparam int TRANS_STEP_MS     = 1;
    localparam int READY_MAX_MS      = 1000;
    localparam int OVP_DLY0_MS       = 5;
    localparam int OVP_DLY1_MS       = 50;
    localparam int OVP_DLY2_MS       = 500;
    localparam int RESTART_UNIT_MS   = 10;
    localparam int BST_WARN_LOW_MV   = 1100;
    localparam int BST_WARN_BASE_MV  = 1200;
    localparam int BST_WARN_STEP_MV  = 50;
    // byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_READY  = 8'h04;
    localparam logic [7:0] ADDR_BOTHR  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_ISTAT  = 8'h10;
    localparam logic [7:0] ADDR_IMASK  = 8'h14;
    localparam logic [7:0] ADDR_SET0   = 8'h20;
    localparam logic [7:0] ADDR_SET1   = 8'h24;
    localparam logic [7:0] ADDR_SET2   = 8'h28;
    localparam logic [7:0] ADDR_SET3   = 8'h2C;
    // control fields
    localparam int CT_EN_OTP = 0;
    localparam int CT_EN_PWR = 1;
    localparam int CT_EN_MBO = 2;
    localparam int CT_EN_BST = 3;
    localparam int CT_EN_OVP = 4;
    localparam int CT_OVP_DIS = 5;
    localparam int CT_PGT    = 6;
    localparam int CT_TRT    = 8;
    localparam int CT_OVD    = 10;
    localparam int CT_BWS    = 12;
    localparam int CT_RUN    = 16;
    localparam int CT_LCLR   = 17;
    localparam logic [31:0] CTRL_MASK = 32'h0003_FFFF;
    // parameter set fields and response bits (1 = safe restart)
    localparam int SF_OPP1 = 0;
    localparam int SF_OCP  = 10;
    localparam int SF_RST  = 20;
    localparam int SF_RESP = 27;
    localparam int RB_OTP  = 0;
    localparam int RB_PWR  = 2;
    // synchroniser lanes and interrupt bits
    localparam int SY_OTP  = 0;
    localparam int SY_OPP1 = 1;
    localparam int SY_OPP2 = 2;
    localparam int SY_MBO  = 3;
    localparam int SY_OVP  = 4;
    localparam int SY_VREG = 5;
    localparam int SY_SEL  = 6;
    localparam int IB_WARN  = 0;
    localparam int IB_READY = 1;
    localparam int IB_STOP  = 2;
    localparam int IB_HALT  = 3;
    localparam int IB_OVP   = 4;
    // reset values
    localparam logic [9:0]  READY_RST = 10'h064;
    localparam logic [11:0] BOTHR_RST = 12'h3E8;
endpackage : pgw_pkg

// *** design/pgw_tmr_if.sv ***
// pgw_tmr_if: start, load and done of one millisecond countdown
// assumes the controller and the timer share pclk
`timescale 1ns/1ps
interface pgw_tmr_if import pgw_pkg::*; ();
    logic             start;
    logic             tick;
    logic [TMR_W-1:0] load;
    logic             busy;
    logic             done;
    modport ctl (output start, tick, load, input busy, done);
    modport tmr (input start, tick, load, output busy, done);
endinterface : pgw_tmr_if

// *** design/pgw_sync.sv ***
// pgw_sync: two flip-flop synchroniser for a group of asynchronous levels
// assumes each lane is an independent level
`timescale 1ns/1ps
module pgw_sync import pgw_pkg::*; #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pgw_sync_s;
    pgw_sync_s r;
    pgw_sync_s n;
    always_comb begin
        n    = r;
        n.s1 = d;
        n.s2 = r.s1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign q = r.s2;
endmodule : pgw_sync

// *** design/pgw_timer.sv ***
// pgw_timer: countdown in millisecond ticks with a one-cycle done pulse
// assumes tick is a one-cycle pulse on pclk
`timescale 1ns/1ps
module pgw_timer import pgw_pkg::*; (
    input  wire logic pclk,
    input  wire logic presetn,
    pgw_tmr_if.tmr    t
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic             busy;
        logic             done;
    } pgw_tmr_s;
    pgw_tmr_s r;
    pgw_tmr_s n;
    always_comb begin
        n      = r;
        n.done = 1'b0;
        if (t.start) begin
            n.cnt  = t.load;
            n.busy = (t.load != '0);
            n.done = (t.load == '0);
        end else if (r.busy && t.tick) begin
            n.cnt = r.cnt - 1'b1;
            if (r.cnt == TMR_W'(1)) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    assign t.busy = r.busy;
    assign t.done = r.done;
    done_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.done |-> $past(t.start) || $past(r.busy)) else $error("done without a running count");
endmodule : pgw_timer

// *** design/pgw_power_good.sv ***
// pgw_power_good: power good prewarning sequencer with apb registers and parameter sets
// assumes detector inputs are asynchronous levels and boost_sense_mv is a pclk-domain sample
`timescale 1ns/1ps
module pgw_power_good import pgw_pkg::*; #(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        otp_det,
    input  wire logic        opp1_trip,
    input  wire logic        opp2_trip,
    input  wire logic        mains_brownout,
    input  wire logic        boost_ovp_det,
    input  wire logic        vout_in_reg,
    input  wire logic [1:0]  set_select_code,
    input  wire logic [11:0] boost_sense_mv,
    output logic             power_good,
    output logic      [7:0]  power_good_level,
    output logic             converter_switch_en,
    output logic      [9:0]  opp1_delay_ms,
    output logic      [9:0]  ocp_delay_cycles,
    output logic      [6:0]  restart_time,
    output logic      [4:0]  protect_safe_restart
);
    localparam int STEP_CYC = MS_CYCLES / RAMP_STEPS;

    typedef enum logic [2:0] {ST_OFF, ST_START, ST_READY, ST_GOOD, ST_WARN, ST_STOP} pgw_state_e;
    typedef struct packed {
        logic [31:0]       ctrl;
        logic [9:0]        ready_ms;
        logic [11:0]       bo_mv;
        logic [IRQ_W-1:0]  stat;
        logic [IRQ_W-1:0]  mask;
        logic [3:0][31:0]  sets;
        pgw_state_e        st;
        logic              pg;
        logic              sw;
        logic              irq;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic [31:0]       act;
        logic [7:0]        level;
        logic [DIV_W-1:0]  ms_div;
        logic [DIV_W-1:0]  rdiv;
        logic              ms_tick;
        logic [1:0]        sel;
        logic [1:0]        cap_cnt;
        logic              sel_taken;
        logic              cause_safe;
        logic              ovp_prev;
        logic              ta_start;
        logic              tb_start;
        logic [TMR_W-1:0]  ta_load;
        logic [TMR_W-1:0]  tb_load;
    } pgw_top_s;

    pgw_top_s          r;
    pgw_top_s          n;
    logic [SYNC_W-1:0] syn;
    logic [31:0]       rd;
    logic              hit;
    logic              wr;
    logic [IRQ_W-1:0]  w1c;
    logic [IRQ_W-1:0]  ev;
    logic              do_stop;
    logic [11:0]       warn_thr;
    logic              run_st;
    logic              halt;
    logic              pwr_any;
    logic              ovp_rise;
    logic              ovp_stop;
    logic              bst_warn;
    logic              tripx;
    logic              trip_en;
    logic              safe_now;
    logic [DIV_W-1:0]  rdiv_max;
    logic [9:0]        ready_clamp;

    pgw_tmr_if ta_if();
    pgw_tmr_if tb_if();

    pgw_sync #(.W(SYNC_W)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({set_select_code, vout_in_reg, boost_ovp_det, mains_brownout,
                   opp2_trip, opp1_trip, otp_det}),
        .q       (syn)
    );
    pgw_timer u_tmr_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (ta_if.tmr)
    );
    pgw_timer u_tmr_ovp (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (tb_if.tmr)
    );
    assign ta_if.start = r.ta_start;
    assign ta_if.load  = r.ta_load;
    assign ta_if.tick  = r.ms_tick;
    assign tb_if.start = r.tb_start;
    assign tb_if.load  = r.tb_load;
    assign tb_if.tick  = r.ms_tick;

    // event decode
    assign run_st   = (r.st == ST_START) || (r.st == ST_READY) || (r.st == ST_GOOD)
                   || (r.st == ST_WARN);
    assign halt     = run_st && (boost_sense_mv < r.bo_mv);
    assign warn_thr = (r.ctrl[CT_BWS+:4] == 4'h0) ? 12'(BST_WARN_LOW_MV) :
                      12'(BST_WARN_BASE_MV + BST_WARN_STEP_MV * (int'(r.ctrl[CT_BWS+:4]) - 1));
    assign bst_warn = r.ctrl[CT_EN_BST] && (boost_sense_mv < warn_thr);
    assign pwr_any  = syn[SY_OPP1] || syn[SY_OPP2];
    assign ovp_rise = syn[SY_OVP] && !r.ovp_prev;
    assign ovp_stop = tb_if.done && syn[SY_OVP];
    assign tripx    = (syn[SY_OTP] && !r.ctrl[CT_EN_OTP]) || (pwr_any && !r.ctrl[CT_EN_PWR])
                   || (syn[SY_MBO] && !r.ctrl[CT_EN_MBO]) || (ovp_stop && !r.ctrl[CT_EN_OVP]);
    assign trip_en  = (syn[SY_OTP] && r.ctrl[CT_EN_OTP])
                   || (pwr_any && r.ctrl[CT_EN_PWR])
                   || (syn[SY_MBO] && r.ctrl[CT_EN_MBO])
                   || (ovp_stop && r.ctrl[CT_EN_OVP])
                   || bst_warn;
    // one response bit covers both overpower levels
    assign safe_now = !((syn[SY_OTP] && !r.act[SF_RESP+RB_OTP])
                     || (pwr_any && !r.act[SF_RESP+RB_PWR]));
    assign rdiv_max = DIV_W'((int'(r.ctrl[CT_TRT+:2]) + 1) * TRANS_STEP_MS * STEP_CYC - 1);
    assign ready_clamp = (r.ready_ms > 10'(READY_MAX_MS)) ? 10'(READY_MAX_MS) : r.ready_ms;

    always_comb begin
        n            = r;
        rd           = '0;
        hit          = 1'b1;
        w1c          = '0;
        ev           = '0;
        do_stop      = 1'b0;
        wr           = psel && penable && r.pready && pwrite;
        n.ms_tick    = 1'b0;
        n.ta_start   = 1'b0;
        n.tb_start   = 1'b0;
        n.pready     = 1'b0;
        n.pslverr    = 1'b0;
        n.ctrl[CT_LCLR] = 1'b0;
        n.ovp_prev   = syn[SY_OVP];
        // millisecond tick
        if (r.ms_div == DIV_W'(MS_CYCLES - 1)) begin
            n.ms_div  = '0;
            n.ms_tick = 1'b1;
        end else begin
            n.ms_div = r.ms_div + 1'b1;
        end
        // set code captured once after the synchroniser settles
        if (!r.sel_taken) begin
            n.cap_cnt = r.cap_cnt + 1'b1;
            if (r.cap_cnt == 2'h3) begin
                n.sel       = syn[SY_SEL+:2];
                n.sel_taken = 1'b1;
            end
        end
        n.act = r.sets[r.sel];
        // apb read decode
        case (paddr)
            ADDR_CTRL:   rd = r.ctrl & CTRL_MASK;
            ADDR_READY:  rd = {22'h00_0000, r.ready_ms};
            ADDR_BOTHR:  rd = {20'h0_0000, r.bo_mv};
            ADDR_STATUS: rd = {17'h0_0000, r.level, r.sel, r.sw, r.pg, r.st};
            ADDR_ISTAT:  rd = {27'h000_0000, r.stat};
            ADDR_IMASK:  rd = {27'h000_0000, r.mask};
            ADDR_SET0, ADDR_SET1, ADDR_SET2, ADDR_SET3: rd = r.sets[paddr[3:2]];
            default:     hit = 1'b0;
        endcase
        if (psel && !penable) begin
            n.pready  = 1'b1;
            n.pslverr = !hit;
            n.prdata  = rd;
        end
        if (wr) begin
            case (paddr)
                ADDR_CTRL:  n.ctrl = pwdata & CTRL_MASK;
                ADDR_READY: n.ready_ms = pwdata[9:0];
                ADDR_BOTHR: n.bo_mv = pwdata[11:0];
                ADDR_ISTAT: w1c = pwdata[IRQ_W-1:0];
                ADDR_IMASK: n.mask = pwdata[IRQ_W-1:0];
                // only delays, restart timer and response bits live in a set
                ADDR_SET0, ADDR_SET1, ADDR_SET2, ADDR_SET3: n.sets[paddr[3:2]] = pwdata;
                default: ;
            endcase
        end
        // boost overvoltage delay, armed only when it disables the converter
        if (ovp_rise) begin
            ev[IB_OVP] = 1'b1;
            if (r.ctrl[CT_OVP_DIS]) begin
                n.tb_start = 1'b1;
                case (r.ctrl[CT_OVD+:2])
                    2'h0:    n.tb_load = TMR_W'(OVP_DLY0_MS);
                    2'h1:    n.tb_load = TMR_W'(OVP_DLY1_MS);
                    default: n.tb_load = TMR_W'(OVP_DLY2_MS);
                endcase
            end
        end
        // sequencer
        case (r.st)
            ST_OFF: begin
                n.pg = 1'b0;
                if (r.ctrl[CT_RUN]) begin
                    n.st = ST_START;
                    n.sw = 1'b1;
                end
            end
            ST_START: begin
                if (syn[SY_VREG]) begin
                    n.st       = ST_READY;
                    n.ta_start = 1'b1;
                    n.ta_load  = TMR_W'(ready_clamp);
                end
            end
            ST_READY: begin
                if (ta_if.done) begin
                    n.st        = ST_GOOD;
                    n.pg        = 1'b1;
                    ev[IB_READY] = 1'b1;
                end
            end
            ST_GOOD: ;
            ST_WARN: begin
                if (ta_if.done) begin
                    do_stop = 1'b1;
                end
            end
            ST_STOP: begin
                if (r.ctrl[CT_LCLR] || (r.cause_safe && ta_if.done)) begin
                    n.st = ST_OFF;
                end
            end
            default: n.st = ST_OFF;
        endcase
        // shutdown requests while converting
        if (run_st && r.st != ST_WARN && (tripx || trip_en)) begin
            n.cause_safe = safe_now;
            if (r.st == ST_GOOD && !tripx) begin
                n.st       = ST_WARN;
                n.pg       = 1'b0;
                n.ta_start = 1'b1;
                n.ta_load  = TMR_W'(PG_TIME_STEP_MS * (int'(r.ctrl[CT_PGT+:2]) + 1));
                ev[IB_WARN] = 1'b1;
            end else begin
                do_stop = 1'b1;
            end
        end
        if (halt) begin
            do_stop      = 1'b1;
            n.cause_safe = 1'b1;
            ev[IB_HALT]  = 1'b1;
        end
        if (do_stop) begin
            n.st        = ST_STOP;
            n.sw        = 1'b0;
            n.pg        = 1'b0;
            n.ta_start  = 1'b1;
            n.ta_load   = TMR_W'(RESTART_UNIT_MS * int'(r.act[SF_RST+:7]));
            ev[IB_STOP] = 1'b1;
        end
        // indication ramp toward the logical level
        if (r.rdiv >= rdiv_max) begin
            n.rdiv = '0;
            if (r.pg && r.level != 8'hFF) begin
                n.level = r.level + 1'b1;
            end else if (!r.pg && r.level != 8'h00) begin
                n.level = r.level - 1'b1;
            end
        end else begin
            n.rdiv = r.rdiv + 1'b1;
        end
        // sticky status, set wins over clear
        n.stat = (r.stat & ~w1c) | ev;
        n.irq  = |(n.stat & n.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.ready_ms <= READY_RST;
            r.bo_mv    <= BOTHR_RST;
        end else begin
            r <= n;
        end
    end

    assign prdata               = r.prdata;
    assign pready               = r.pready;
    assign pslverr              = r.pslverr;
    assign irq                  = r.irq;
    assign power_good           = r.pg;
    assign power_good_level     = r.level;
    assign converter_switch_en  = r.sw;
    assign opp1_delay_ms        = r.act[SF_OPP1+:10];
    assign ocp_delay_cycles     = r.act[SF_OCP+:10];
    assign restart_time         = r.act[SF_RST+:7];
    assign protect_safe_restart = r.act[SF_RESP+:5];

    prewarn_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_WARN |-> r.sw && !r.pg) else $error("switching lost in prewarning");
    warn_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_WARN && !halt ##1 r.st == ST_STOP |-> $past(ta_if.done))
        else $error("prewarning ended early");
    otp_warn_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_GOOD && syn[SY_OTP] && r.ctrl[CT_EN_OTP] && !tripx && !halt
        |=> r.st == ST_WARN && !r.pg) else $error("no prewarning on overtemperature");
    pwr_warn_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_GOOD && pwr_any && r.ctrl[CT_EN_PWR] && !tripx && !halt
        |=> r.st == ST_WARN) else $error("no prewarning on overpower");
    mbo_warn_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_GOOD && syn[SY_MBO] && r.ctrl[CT_EN_MBO] && !tripx && !halt
        |=> r.st == ST_WARN) else $error("no prewarning on mains brownout");
    boost_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        halt |=> !r.sw && r.st == ST_STOP) else $error("switching not halted");
    boost_warn_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_GOOD && bst_warn |=> !r.pg) else $error("boost warning missed");
    ovp_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        ovp_rise && !r.ctrl[CT_OVP_DIS] |=> !r.tb_start) else $error("ovp delay armed");
    ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_READY ##1 r.st == ST_GOOD |-> $past(ta_if.done))
        else $error("power good before ready delay");
    ramp_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.level != $past(r.level) |-> (8'(r.level - $past(r.level)) == 8'h01)
        || (8'($past(r.level) - r.level) == 8'h01)) else $error("ramp jumped");
    set_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.sel_taken ##1 r.sel_taken |-> r.act == $past(r.sets[r.sel]))
        else $error("active set mismatch");
    good_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        r.st == ST_GOOD |-> r.pg && r.sw) else $error("power good dropped without event");
endmodule : pgw_power_good

// *** dv/pgw_load_model.sv ***
// pgw_load_model: load side watching power good, times the warning and the ramp
// assumes power good and switching levels come from the device on pclk
`timescale 1ns/1ps
module pgw_load_model (
    input  wire logic       pclk,
    input  wire logic       power_good,
    input  wire logic [7:0] power_good_level,
    input  wire logic       converter_switch_en,
    output int              warn_len,
    output int              ramp_len
);
    int   wc = 0;
    int   rc = 0;
    logic pg_q = 1'b0;
    logic arm_q = 1'b0;
    always @(posedge pclk) begin
        pg_q <= power_good;
        if (pg_q && !power_good) begin
            arm_q <= 1'b1;
            wc <= 1;
        end else if (arm_q && !converter_switch_en) begin
            arm_q <= 1'b0;
            warn_len <= wc;
        end else if (arm_q) begin
            wc <= wc + 1;
        end
        if (!pg_q && power_good) begin
            rc <= 1;
        end else if (rc > 0 && power_good_level != 8'hFF) begin
            rc <= rc + 1;
        end else if (rc > 0) begin
            ramp_len <= rc;
            rc <= 0;
        end
    end
endmodule : pgw_load_model

// *** dv/power_good_prewarning_test.sv ***
// power_good_prewarning_test: random prewarn events, ready delay, halt and interrupt
// assumes pgw_power_good with a short millisecond and the load model beside it
`timescale 1ns/1ps
module power_good_prewarning_test import pgw_pkg::*; ;
    localparam int MS = 300;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, lvl;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, irq, power_good, sw, err;
    logic [5:0] det = 0;
    logic [1:0] sel = 0;
    logic [11:0] bsmv = 12'd3000;
    logic [9:0] o1, oc;
    logic [6:0] rt;
    logic [4:0] psr;
    int mismatches = 0, compares = 0, cyc = 0, warn_len, ramp_len;
    pgw_power_good #(.MS_CYCLES(MS)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .otp_det(det[0]), .opp1_trip(det[1]),
        .opp2_trip(det[2]), .mains_brownout(det[3]), .boost_ovp_det(det[4]),
        .vout_in_reg(det[5]), .set_select_code(sel), .boost_sense_mv(bsmv),
        .power_good(power_good), .power_good_level(lvl), .converter_switch_en(sw),
        .opp1_delay_ms(o1), .ocp_delay_cycles(oc), .restart_time(rt),
        .protect_safe_restart(psr));
    pgw_load_model load_u (.pclk(pclk), .power_good(power_good), .power_good_level(lvl),
        .converter_switch_en(sw), .warn_len(warn_len), .ramp_len(ramp_len));
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 90000) begin
            mismatches++;
            finish_test();
        end
    end
    function automatic int thr(int k);
        return k == 0 ? BST_WARN_LOW_MV : BST_WARN_BASE_MV + BST_WARN_STEP_MV * (k - 1);
    endfunction : thr
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic near(string nm, int e, int tol, int g);
        compares++;
        if (g < e - tol || g > e + tol) begin
            mismatches++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask : near
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic wt(ref logic s, input logic v);
        for (int i = 0; i < 9000 && s !== v; i++) @(posedge pclk);
        if (s !== v) begin
            mismatches++;
            $display("MISMATCH wait expected %b seen %b", v, s);
        end
    endtask : wt
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    initial begin
        int n, r, k, ev, rdy, t0;
        logic [31:0] s[4];
        void'($urandom(32'h192881e7));
        sel <= 2'($urandom);
        repeat (5) @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_READY, 0); chk("ready_rst", 32'h0000_0064, rd);
        apb(0, ADDR_BOTHR, 0); chk("bothr_rst", 32'h0000_03E8, rd);
        apb(0, 8'h40, 0); chk("unmapped_err", 1, {31'h0, err});
        for (int i = 0; i < 4; i++) begin
            s[i] = {5'h1F, 7'h00, 20'($urandom)};
            apb(1, ADDR_SET0 + 8'(4 * i), s[i]);
        end
        repeat (2) @(posedge pclk);
        chk("opp1", s[sel][9:0], o1);
        chk("ocp", s[sel][19:10], oc);
        chk("resp", {7'h00, 5'h1F}, {rt, psr});
        $display("test sets done");
        rdy = $urandom_range(4, 0);
        apb(1, ADDR_BOTHR, 500);
        apb(1, ADDR_READY, 32'(rdy));
        for (ev = 0; ev < 7; ev++) begin
            n = $urandom_range(3, 0); r = $urandom_range(3, 0); k = $urandom_range(15, 0);
            apb(1, ADDR_CTRL,
                32'(32'h0001_001E | (ev != 6 ? 32'h21 : 0) | n << 6 | r << 8 | k << 12));
            for (int i = 0; i < 9000 && lvl !== 8'h00; i++) @(posedge pclk);
            det[5] <= 1'b1;
            t0 = cyc;
            wt(power_good, 1);
            if (ev == 0) near("ready_dly", rdy * MS, MS + 10, cyc - t0);
            repeat ((r + 1) * MS + 20) @(posedge pclk);
            near("ramp", (r + 1) * MS, (r + 1) * MS / 4 + 5, ramp_len);
            apb(0, ADDR_STATUS, 0); chk("status", {sel, 5'h1B}, rd[6:0]);
            if (ev == 4) bsmv <= 12'(thr(k) - 10);
            else det[ev == 6 ? 0 : (ev == 5 ? 4 : ev)] <= 1'b1;
            if (ev == 6) det[4] <= 1'b1;
            wt(sw, 0);
            repeat (2) @(posedge pclk);
            near("warn", ev == 6 ? 0 : PG_TIME_STEP_MS * (n + 1) * MS,
                 ev == 6 ? 3 : MS + 5, warn_len);
            det <= 0; bsmv <= 12'd3000;
            $display("test event %0d done", ev);
        end
        det[5] <= 1'b1;
        wt(power_good, 1);
        apb(1, ADDR_IMASK, 32'h8);
        bsmv <= 12'd400;
        t0 = cyc;
        wt(sw, 0);
        near("halt_dly", 2, 2, cyc - t0);
        apb(1, ADDR_CTRL, 0);
        repeat (2) @(posedge pclk);
        chk("irq_on", 1, {31'h0, irq});
        apb(1, ADDR_IMASK, 0);
        repeat (2) @(posedge pclk);
        chk("irq_mask", 0, {31'h0, irq});
        apb(0, ADDR_ISTAT, 0); chk("halt_set", 1, {31'h0, rd[3]});
        apb(1, ADDR_ISTAT, 32'h8);
        apb(1, ADDR_IMASK, 32'h8);
        repeat (2) @(posedge pclk);
        chk("irq_clr", 0, {31'h0, irq});
        apb(0, ADDR_ISTAT, 0); chk("halt_clr", 0, {31'h0, rd[3]});
        $display("test halt done");
        finish_test();
    end
endmodule : power_good_prewarning_test
